/* File: verilog/pmcr_regs.svh */
`ifndef PMCR_REGS_SVH
`define PMCR_REGS_SVH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define PMCR_DEV_CAP2       10'h064
`define PMCR_DEV_CTL2       10'h068
`define PMCR_DEV_STS2       10'h06A
`define PMCR_LNK_CAP2       10'h06C
`define PMCR_LNK_CTL2       10'h070
`define PMCR_LNK_STS2       10'h072
`define PMCR_SLT_CAP2       10'h074
`define PMCR_SLT_CTL2       10'h078
`define PMCR_SLT_STS2       10'h07A
`define PMCR_PM_HDR         10'h0C0
`define PMCR_FWD_CTRL       10'h0E0
`define PMCR_PORT_STAT      10'h0E4

// ********************************************************************
// Capability header fields
// ********************************************************************
`define PMCR_CAPABILITY_IDENTIFIER_MSB      7
`define PMCR_CAPABILITY_IDENTIFIER_LSB      0
`define PMCR_CAPABILITY_IDENTIFIER_VAL      8'h01
`define PMCR_NXT_MSB        15
`define PMCR_NXT_LSB        8
`define PMCR_NXT_UP         8'h00
`define PMCR_NXT_DOWN       8'hD0
`define PMCR_VER_MSB        18
`define PMCR_VER_LSB        16
`define PMCR_VER_VAL        3'h3
`define PMCR_CLK_BIT        19
`define PMCR_DEVICE_SPECIFIC_INIT_FLAG_BIT      21
`define PMCR_DEVICE_SPECIFIC_INIT_FLAG_DEF      1'h0
`define PMCR_AUX_MSB        24
`define PMCR_AUX_LSB        22
`define PMCR_D1_BIT         25
`define PMCR_D2_BIT         26
`define PMCR_PME_MSB        31
`define PMCR_PME_LSB        27
`define PMCR_PME_DEF        5'h19

// ********************************************************************
// Own control and status fields
// ********************************************************************
`define PMCR_FWD_EN_BIT     0
`define PMCR_FWD_EN_DEF     1'h1
`define PMCR_ST_VALID_BIT   0
`define PMCR_ST_UP_BIT      1
`define PMCR_ST_DROP_BIT    2
`define PMCR_ST_INIT_BIT    3
`define PMCR_ROLE_WAIT      2'h2

`endif

/* File: verilog/pmcr_pkg.sv */
package pmcr_pkg;

  // Power states as seen by the forwarding logic
  typedef enum logic [2:0] {
    PMCR_D0,
    PMCR_D1,
    PMCR_D2,
    PMCR_D3HOT,
    PMCR_D3COLD
  } pmcr_pwr_t;

  typedef logic [9:0]  pmcr_idx_t;
  typedef logic [31:0] pmcr_word_t;

endpackage : pmcr_pkg

/* File: verilog/pmcr_bank.sv */
`timescale 1ns/100ps
`include "pmcr_regs.svh"
// Contract
// - Capability id byte always reads one.
// - Upstream port next pointer defaults to zero, end of list.
// - Downstream port next pointer defaults to the MSI structure offset.
// - Version field is read-only and reads three.
// - Wake clock bit is read-only zero.
// - Device specific init flag defaults to zero.
// - Aux current field is read-only zero.
// - D1 and D2 support bits are read-only zero.
// - PME support field defaults to bits 27, 30 and 31 set.
// - Wake messages are never forwarded in D3cold.
// - Loading the PME field changes only the advertised value.
module pmcr_bank (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Port role strap, from a pin
  input  wire logic        STRAP_UPSTREAM,
  // Initialization load path
  input  wire logic        INIT_WE,
  input  wire logic [31:0] INIT_DATA,
  // Wake message forwarding
  input  wire logic [2:0]  PWR_STATE,
  input  wire logic        PME_IN,
  output logic             PME_FWD
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic                strap_s1_q;
  logic                strap_s2_q;
  logic [1:0]          role_cnt_q;
  logic                role_valid_q;
  logic                upstream_q;
  logic [7:0]          nxt_q;
  logic                device_specific_init_flag_q;
  logic [4:0]          pme_adv_q;
  logic                init_seen_q;
  logic                fwd_en_q;
  logic                drop_q;
  logic                pme_fwd_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  pmcr_pkg::pmcr_word_t hdr;
  pmcr_pkg::pmcr_word_t stat;
  pmcr_pkg::pmcr_word_t rd_word;
  pmcr_pkg::pmcr_idx_t  idx;
  logic                hit;
  logic                rsvd_hit;
  logic                setup;
  logic                access;
  logic                wr_access;
  logic                pme_allowed;
  logic                drop_now;
  logic                drop_clr;
  // Wake behaviour stays frozen to the reset mask, whatever gets loaded
  localparam logic [4:0] pme_fixed_mask = `PMCR_PME_DEF;

  assign setup     = PSEL && !PENABLE;
  assign access    = PSEL && PENABLE;
  assign wr_access = access && PWRITE && !PSLVERR;
  assign idx       = PADDR[11:2];

  // ******************************************************************
  // Strap synchroniser and role capture
  // ******************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end else begin
      strap_s1_q <= STRAP_UPSTREAM;
      strap_s2_q <= strap_s1_q;
    end
  end

  // Wait until the synchroniser holds a real strap sample
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      role_cnt_q   <= 2'h0;
      role_valid_q <= 1'b0;
      upstream_q   <= 1'b0;
    end else if (!role_valid_q) begin
      if (role_cnt_q == `PMCR_ROLE_WAIT) begin
        role_valid_q <= 1'b1;
        upstream_q   <= strap_s2_q;
      end else begin
        role_cnt_q <= role_cnt_q + 2'h1;
      end
    end
  end

  // ******************************************************************
  // Loadable capability fields
  // ******************************************************************
  // Upstream end of list
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      nxt_q <= `PMCR_NXT_UP;
    end else if (INIT_WE) begin
      nxt_q <= INIT_DATA[`PMCR_NXT_MSB:`PMCR_NXT_LSB];
    end else if (!role_valid_q && role_cnt_q == `PMCR_ROLE_WAIT) begin
      nxt_q <= strap_s2_q ? `PMCR_NXT_UP : `PMCR_NXT_DOWN;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      device_specific_init_flag_q     <= `PMCR_DEVICE_SPECIFIC_INIT_FLAG_DEF;
      pme_adv_q   <= `PMCR_PME_DEF;
      init_seen_q <= 1'b0;
    end else if (INIT_WE) begin
      device_specific_init_flag_q     <= INIT_DATA[`PMCR_DEVICE_SPECIFIC_INIT_FLAG_BIT];
      pme_adv_q   <= INIT_DATA[`PMCR_PME_MSB:`PMCR_PME_LSB];
      init_seen_q <= 1'b1;
    end
  end

  // ******************************************************************
  // Header word assembly
  // ******************************************************************
  // Fixed capability id
  always_comb begin
    hdr = '0;
    hdr[`PMCR_CAPABILITY_IDENTIFIER_MSB:`PMCR_CAPABILITY_IDENTIFIER_LSB] = `PMCR_CAPABILITY_IDENTIFIER_VAL;
    hdr[`PMCR_NXT_MSB:`PMCR_NXT_LSB]     = nxt_q;
    hdr[`PMCR_VER_MSB:`PMCR_VER_LSB]     = `PMCR_VER_VAL;
    hdr[`PMCR_CLK_BIT]                   = 1'b0;
    hdr[`PMCR_DEVICE_SPECIFIC_INIT_FLAG_BIT]                 = device_specific_init_flag_q;
    hdr[`PMCR_AUX_MSB:`PMCR_AUX_LSB]     = 3'h0;
    hdr[`PMCR_D1_BIT]                    = 1'b0;
    hdr[`PMCR_D2_BIT]                    = 1'b0;
    hdr[`PMCR_PME_MSB:`PMCR_PME_LSB]     = pme_adv_q;
  end

  always_comb begin
    stat = '0;
    stat[`PMCR_ST_VALID_BIT] = role_valid_q;
    stat[`PMCR_ST_UP_BIT]    = upstream_q;
    stat[`PMCR_ST_DROP_BIT]  = drop_q;
    stat[`PMCR_ST_INIT_BIT]  = init_seen_q;
  end

  // ******************************************************************
  // Address decode and read mux
  // ******************************************************************
  // Reserved block reads zero
  always_comb begin
    rsvd_hit = 1'b0;
    hit      = 1'b1;
    rd_word  = '0;
    unique case (idx)
      `PMCR_DEV_CAP2, `PMCR_DEV_CTL2, `PMCR_DEV_STS2,
      `PMCR_LNK_CAP2, `PMCR_LNK_CTL2, `PMCR_LNK_STS2,
      `PMCR_SLT_CAP2, `PMCR_SLT_CTL2, `PMCR_SLT_STS2: begin
        rsvd_hit = 1'b1;
      end
      `PMCR_PM_HDR: begin
        rd_word = hdr;
      end
      `PMCR_FWD_CTRL: begin
        rd_word[`PMCR_FWD_EN_BIT] = fwd_en_q;
      end
      `PMCR_PORT_STAT: begin
        rd_word = stat;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    // Unaligned byte addresses never match a word
    if (PADDR[1:0] != 2'h0) begin
      hit      = 1'b0;
      rsvd_hit = 1'b0;
      rd_word  = '0;
    end
  end

  // Answer is computed in setup so the access phase needs no wait
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (setup) begin
      prdata_q  <= PWRITE ? 32'h0000_0000 : rd_word;
      pslverr_q <= !hit;
    end else if (!PSEL) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_q;
  assign PSLVERR = pslverr_q && access;

  // ******************************************************************
  // Software control register
  // ******************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fwd_en_q <= `PMCR_FWD_EN_DEF;
    end else if (wr_access && idx == `PMCR_FWD_CTRL && PSTRB[0]) begin
      fwd_en_q <= PWDATA[`PMCR_FWD_EN_BIT];
    end
  end

  // ******************************************************************
  // Wake message forwarding
  // ******************************************************************
  // Never in D3cold
  always_comb begin
    pme_allowed = 1'b0;
    unique case (PWR_STATE)
      pmcr_pkg::PMCR_D0:     pme_allowed = pme_fixed_mask[0];
      pmcr_pkg::PMCR_D1:     pme_allowed = pme_fixed_mask[1];
      pmcr_pkg::PMCR_D2:     pme_allowed = pme_fixed_mask[2];
      pmcr_pkg::PMCR_D3HOT:  pme_allowed = pme_fixed_mask[3];
      pmcr_pkg::PMCR_D3COLD: pme_allowed = 1'b0;
      default:               pme_allowed = 1'b0;
    endcase
  end

  assign drop_now = PME_IN && !(pme_allowed && fwd_en_q);
  assign drop_clr = wr_access && idx == `PMCR_PORT_STAT && PSTRB[0]
                    && PWDATA[`PMCR_ST_DROP_BIT];

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pme_fwd_q <= 1'b0;
    end else begin
      pme_fwd_q <= PME_IN && pme_allowed && fwd_en_q;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      drop_q <= 1'b0;
    end else if (drop_now) begin
      drop_q <= 1'b1;
    end else if (drop_clr) begin
      drop_q <= 1'b0;
    end
  end

  assign PME_FWD = pme_fwd_q;

  // ******************************************************************
  // Checks
  // ******************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  a_capability_identifier_fixed: assert property (
    access && !PWRITE && idx == `PMCR_PM_HDR && !PSLVERR |->
      PRDATA[`PMCR_CAPABILITY_IDENTIFIER_MSB:`PMCR_CAPABILITY_IDENTIFIER_LSB] == `PMCR_CAPABILITY_IDENTIFIER_VAL)
    else $error("capability id not one");

  a_upstream_last: assert property (
    role_valid_q && upstream_q && !init_seen_q |-> nxt_q == `PMCR_NXT_UP)
    else $error("upstream next pointer not zero");

  a_downstream_link: assert property (
    role_valid_q && !upstream_q && !init_seen_q |-> nxt_q == `PMCR_NXT_DOWN)
    else $error("downstream next pointer not MSI offset");

  a_version_three: assert property (
    access && !PWRITE && idx == `PMCR_PM_HDR && !PSLVERR |->
      PRDATA[`PMCR_VER_MSB:`PMCR_VER_LSB] == `PMCR_VER_VAL)
    else $error("version field not three");

  a_wake_clk_zero: assert property (
    access && idx == `PMCR_PM_HDR |-> PRDATA[`PMCR_CLK_BIT] == 1'b0)
    else $error("wake clock bit set");

  a_device_specific_init_flag_default: assert property (
    !init_seen_q |-> hdr[`PMCR_DEVICE_SPECIFIC_INIT_FLAG_BIT] == `PMCR_DEVICE_SPECIFIC_INIT_FLAG_DEF)
    else $error("init flag not zero before load");

  a_aux_zero: assert property (
    access && idx == `PMCR_PM_HDR |->
      PRDATA[`PMCR_AUX_MSB:`PMCR_AUX_LSB] == 3'h0)
    else $error("aux current not zero");

  a_d1_d2_zero: assert property (
    access && idx == `PMCR_PM_HDR |->
      !PRDATA[`PMCR_D1_BIT] && !PRDATA[`PMCR_D2_BIT])
    else $error("D1 or D2 advertised");

  a_pme_default: assert property (
    !init_seen_q |-> hdr[`PMCR_PME_MSB:`PMCR_PME_LSB] == `PMCR_PME_DEF)
    else $error("PME support not default before load");

  a_d3cold_block: assert property (
    PME_IN && PWR_STATE == pmcr_pkg::PMCR_D3COLD |=> !PME_FWD)
    else $error("PME forwarded in D3cold");

  a_pme_behaviour: assert property (
    PME_IN && fwd_en_q && PWR_STATE == pmcr_pkg::PMCR_D3HOT |=> PME_FWD)
    else $error("PME not forwarded in D3hot");

  a_pme_blocked_state: assert property (
    PME_IN && !pme_allowed |=> !PME_FWD)
    else $error("PME forwarded in a state outside the fixed mask");

  a_drop_set_wins: assert property (
    drop_now |=> drop_q)
    else $error("blocked PME not recorded");

  a_rsvd_zero: assert property (
    setup && rsvd_hit |=> PRDATA == 32'h0000_0000 && !PSLVERR)
    else $error("reserved register not zero");

  a_cfg_readonly: assert property (
    wr_access && idx == `PMCR_PM_HDR && !INIT_WE && role_valid_q |=>
      hdr == $past(hdr))
    else $error("header changed by config write");

endmodule : pmcr_bank

/* File: test/pmcr_bank_test.sv */
`timescale 1ns/100ps
`include "pmcr_regs.svh"
module pmcr_bank_test;
  // ********************************************************************
  // Stimulus and observation
  // ********************************************************************
  logic        clk, rst_n, psel, penable, pwrite, strap, init_we, pme_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, init_data, rd, w;
  logic [3:0]  pstrb;
  logic [2:0]  pwr_state;
  logic        pready, pslverr, pme_fwd, er;
  logic [31:0] prdata;
  int          mismatches, checks_done;
  logic [9:0]  rsv_idx [9] = '{`PMCR_DEV_CAP2, `PMCR_DEV_CTL2, `PMCR_DEV_STS2,
                               `PMCR_LNK_CAP2, `PMCR_LNK_CTL2, `PMCR_LNK_STS2,
                               `PMCR_SLT_CAP2, `PMCR_SLT_CTL2, `PMCR_SLT_STS2};

  pmcr_bank pmcr_bank_i (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready),
    .PRDATA(prdata), .PSLVERR(pslverr), .STRAP_UPSTREAM(strap),
    .INIT_WE(init_we), .INIT_DATA(init_data), .PWR_STATE(pwr_state),
    .PME_IN(pme_in), .PME_FWD(pme_fwd)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] exp_hdr(input logic [7:0] nxt, input logic device_specific_init_flag,
                                          input logic [4:0] pme);
    return {pme, 1'h0, 1'h0, 3'h0, device_specific_init_flag, 1'h0, 1'h0, `PMCR_VER_VAL, nxt, `PMCR_CAPABILITY_IDENTIFIER_VAL};
  endfunction : exp_hdr

  task automatic results;
    $display("Checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checks_done++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Master never assumes zero wait states; the wait is bounded instead
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic reset_dut(input logic up);
    @(posedge clk);
    rst_n <= 1'h0;
    strap <= up;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    repeat (6) @(posedge clk);
  endtask : reset_dut

  task automatic pme_try(input logic [2:0] st, input logic ex);
    @(posedge clk);
    pwr_state <= st;
    pme_in    <= 1'h1;
    @(posedge clk);
    pme_in <= 1'h0;
    @(negedge clk);
    chk("pme_fwd", {31'h0, ex}, {31'h0, pme_fwd});
    @(negedge clk);
    chk("pme_fwd_end", 32'h0, {31'h0, pme_fwd});
  endtask : pme_try

  // ********************************************************************
  // Clock, watchdog and main sequence
  // ********************************************************************
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    {rst_n, psel, penable, pwrite, strap, init_we, pme_in} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    init_data = 32'h0;
    pstrb = 4'hF;
    pwr_state = 3'h0;
    mismatches = 0;
    checks_done = 0;
    void'($urandom(44));
    reset_dut(1'h0);
    apb(1'h0, {`PMCR_PM_HDR, 2'h0}, 32'h0);
    chk("hdr_down", exp_hdr(8'hD0, 1'h0, 5'h19), rd);
    apb(1'h0, {`PMCR_PORT_STAT, 2'h0}, 32'h0);
    chk("stat_down", 32'h1, rd & 32'hF);
    // Reserved words: random writes must leave nothing behind
    for (int i = 0; i < 9; i++) begin
      apb(1'h1, {rsv_idx[i], 2'h0}, $urandom);
      chk("rsv_wr_err", 32'h0, {31'h0, er});
      apb(1'h0, {rsv_idx[i], 2'h0}, 32'h0);
      chk("rsv_rd", 32'h0, rd);
    end
    apb(1'h1, {`PMCR_PM_HDR, 2'h0}, 32'hFFFFFFFF);
    apb(1'h0, {`PMCR_PM_HDR, 2'h0}, 32'h0);
    chk("hdr_cfg_wr", exp_hdr(8'hD0, 1'h0, 5'h19), rd);
    apb(1'h0, 12'h004, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
    // Init path loads, second image clears the advertised wake states
    for (int k = 0; k < 2; k++) begin
      w = (k == 0) ? $urandom : ($urandom & 32'h07FFFFFF);
      @(posedge clk);
      init_we   <= 1'h1;
      init_data <= w;
      @(posedge clk);
      init_we <= 1'h0;
      apb(1'h0, {`PMCR_PM_HDR, 2'h0}, 32'h0);
      chk("hdr_init", exp_hdr(w[15:8], w[21], w[31:27]), rd);
    end
    for (int s = 0; s < 8; s++)
      pme_try(s[2:0], (s == 0) || (s == 3));
    apb(1'h1, {`PMCR_PORT_STAT, 2'h0}, 32'h4);
    apb(1'h0, {`PMCR_PORT_STAT, 2'h0}, 32'h0);
    chk("stat_clr", 32'h8, rd & 32'hC);
    apb(1'h1, {`PMCR_FWD_CTRL, 2'h0}, 32'h0);
    apb(1'h0, {`PMCR_FWD_CTRL, 2'h0}, 32'h0);
    chk("fwd_ctrl", 32'h0, rd);
    pme_try(3'h0, 1'h0);
    apb(1'h0, {`PMCR_PORT_STAT, 2'h0}, 32'h0);
    chk("stat_blocked", 32'h4, rd & 32'h4);
    reset_dut(1'h1);
    apb(1'h0, {`PMCR_PM_HDR, 2'h0}, 32'h0);
    chk("hdr_up", exp_hdr(8'h00, 1'h0, 5'h19), rd);
    apb(1'h0, {`PMCR_PORT_STAT, 2'h0}, 32'h0);
    chk("stat_up", 32'h3, rd & 32'hF);
    results();
  end
endmodule : pmcr_bank_test
